// ==== logic/cnlss_regs.vh ====
// constants for the canopen node layer-setting and pdo block
`ifndef CNLSS_REGS_VH
`define CNLSS_REGS_VH

// apb register byte offsets
`define CN_OFF_STATUS 12'h000
`define CN_OFF_SERIAL 12'h004
`define CN_OFF_ODADDR 12'h008
`define CN_OFF_ODDATA 12'h00c
`define CN_OFF_ODSTAT 12'h010
`define CN_OFF_NODE 12'h014
`define CN_SERIAL_RST 32'h00000000

// identity defaults, values arbitrary
`define CN_VENDOR_DEF 32'h00005a01
`define CN_PRODUCT_DEF 32'h00005a02
`define CN_REVISION_DEF 32'h00005a03

// decoded message kinds from the can controller
`define CN_MSG_SW_GLOBAL 3'h0
`define CN_MSG_SW_SELECT 3'h1
`define CN_MSG_CFG_ID 3'h2
`define CN_MSG_CFG_BT 3'h3
`define CN_MSG_STORE 3'h4
`define CN_MSG_NMT 3'h5
`define CN_MSG_SYNC 3'h6
`define CN_SW_ARG_WAIT 8'h00
`define CN_SW_ARG_CFG 8'h01

// network management commands and states
`define CN_NMT_START 8'h01
`define CN_NMT_STOP 8'h02
`define CN_NMT_PREOP 8'h80
`define CN_NMT_RST_NODE 8'h81
`define CN_NMT_RST_COMM 8'h82
`define CN_ST_INIT 2'h0
`define CN_ST_PREOP 2'h1
`define CN_ST_OP 2'h2
`define CN_ST_STOP 2'h3

// node id and bit timing
`define CN_ID_MIN 7'h01
`define CN_ID_MAX 7'h7f
`define CN_ID_DEF 7'h70
`define CN_BT_DEF 4'h8
`define CN_BT_MAX 4'h8
`define CN_KBPS_DEF 10'd10

// pdo transmission
`define CN_TT_SYNC 8'h01
`define CN_TT_EVENT 8'hff
`define CN_EVT_DEF 16'h0000
`define CN_MS_NS 1000000
`define CN_CLK_NS 10

// object dictionary
`define CN_COMM_LO 16'h1000
`define CN_COMM_HI 16'h1fff
`define CN_MFR_LO 16'h2000
`define CN_MFR_HI 16'h5fff
`define CN_DEV_LO 16'h6000
`define CN_DEV_HI 16'h9fff
`define CN_IDX_RPDO_COMM 16'h1400
`define CN_IDX_TPDO_COMM 16'h1800
`define CN_COB_RPDO 11'h200
`define CN_COB_TPDO 11'h180
`define CN_SUB_COUNT 8'h00
`define CN_SUB_COB 8'h01
`define CN_SUB_TT 8'h02
`define CN_SUB_EVT 8'h05
`define CN_TPDO_SUBS 8'h05
`define CN_RPDO_SUBS 8'h02
`define CN_MFR_SUBS 8'h04
`define CN_RG_COMM 3'h1
`define CN_RG_MFR 3'h2
`define CN_RG_DEV 3'h3
`define CN_RG_OTHER 3'h0

`endif

// ==== logic/cnlss_od_mem.v ====
// object dictionary value memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module cnlss_od_mem (
  // clock
  input wire pclk,
  // write port
  input wire we,
  input wire [3:0] waddr,
  input wire [31:0] wdata,
  // read port
  input wire [3:0] raddr,
  output reg [31:0] rdata
);
  reg [31:0] mem [0:15];

  always @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// ==== logic/cnlss_node.v ====
// canopen node: layer settings, nmt states, tpdo triggers, sdo object access over apb
// What this block does
// - layer-setting state is waiting or configuration and starts in waiting.
// - in configuration the node accepts node id and bit timing commands.
// - in waiting the node runs normally and applies no id or rate change.
// - a selective switch enters configuration only if all four identity values match.
// - a global switch naming configuration enters it whatever the identity.
// - a configured node id must lie in 0x01 to 0x7f, other values are refused.
// - bit timing index 0 to 8 maps to 1 Mbps down to 10 kbps.
// - store keeps the configured id and rate, a global switch to waiting applies them.
// - without reconfiguration the node uses id 0x70 and 10 kbps.
// - transmission type 1 sends the tpdo on every sync.
// - transmission type 255 sends the tpdo every event-timer milliseconds.
// - tpdo and rpdo configuration objects are readable.
// - states init, pre-operational, operational, stopped; sdo in preop and op, pdo in op.
// - communication, manufacturer and device objects sit in their index regions.
// - multi-element objects serve each element at its own sub-index from 1.
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "cnlss_regs.vh"
module cnlss_node #(
  parameter [31:0] VENDOR_ID = `CN_VENDOR_DEF,
  parameter [31:0] PRODUCT_CODE = `CN_PRODUCT_DEF,
  parameter [31:0] REVISION = `CN_REVISION_DEF,
  parameter integer MS_CYCLES = `CN_MS_NS / `CN_CLK_NS
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // decoded messages from the can controller
  input wire msg_valid,
  input wire [2:0] msg_type,
  input wire [7:0] msg_arg,
  input wire [31:0] msg_vendor,
  input wire [31:0] msg_product,
  input wire [31:0] msg_revision,
  input wire [31:0] msg_serial,
  // layer-setting status
  output wire lss_config,
  output wire lss_ack,
  output wire lss_err,
  // active settings
  output wire [6:0] node_id,
  output wire [3:0] bit_timing,
  output wire [9:0] bitrate_kbps,
  // network state and pdo
  output wire [1:0] nmt_state,
  output wire sdo_allowed,
  output wire pdo_allowed,
  output wire tpdo_tx
);
  function [9:0] bt_rate;
    input [3:0] idx;
    begin
      case (idx)
        4'h0: bt_rate = 10'd1000;
        4'h1: bt_rate = 10'd800;
        4'h2: bt_rate = 10'd500;
        4'h3: bt_rate = 10'd250;
        4'h4: bt_rate = 10'd125;
        4'h5: bt_rate = 10'd100;
        4'h6: bt_rate = 10'd50;
        4'h7: bt_rate = 10'd20;
        default: bt_rate = 10'd10;
      endcase
    end
  endfunction
  reg lss_cfg_q;
  reg lss_ack_q;
  reg lss_err_q;
  reg [6:0] node_id_q;
  reg [6:0] pend_id_q;
  reg [6:0] stored_id_q;
  reg [3:0] bt_q;
  reg [3:0] pend_bt_q;
  reg [3:0] stored_bt_q;
  reg [9:0] kbps_q;
  reg [1:0] nmt_q;
  reg [7:0] tt_q;
  reg [15:0] evt_q;
  reg [16:0] ms_cnt_q;
  reg [15:0] evt_cnt_q;
  reg tpdo_q;
  reg [31:0] serial_q;
  reg [31:0] od_addr_q;
  reg [31:0] od_rdata_q;
  reg od_err_q;
  reg [2:0] fetch_q;
  reg [31:0] prdata_q;
  wire is_msg = msg_valid;
  wire id_match = (msg_vendor == VENDOR_ID) && (msg_product == PRODUCT_CODE) &&
                  (msg_revision == REVISION) && (msg_serial == serial_q);
  wire sync_in = is_msg && (msg_type == `CN_MSG_SYNC);
  // layer-setting services
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lss_cfg_q <= 1'b0;
      lss_ack_q <= 1'b0;
      lss_err_q <= 1'b0;
      node_id_q <= `CN_ID_DEF;
      pend_id_q <= `CN_ID_DEF;
      stored_id_q <= `CN_ID_DEF;
      bt_q <= `CN_BT_DEF;
      pend_bt_q <= `CN_BT_DEF;
      stored_bt_q <= `CN_BT_DEF;
    end else begin
      lss_ack_q <= 1'b0;
      lss_err_q <= 1'b0;
      if (is_msg) begin
        case (msg_type)
          `CN_MSG_SW_GLOBAL: begin
            if (msg_arg == `CN_SW_ARG_CFG) begin
              lss_cfg_q <= 1'b1;
              if (!lss_cfg_q) begin
                pend_id_q <= node_id_q;
                pend_bt_q <= bt_q;
              end
            end else if (msg_arg == `CN_SW_ARG_WAIT && lss_cfg_q) begin
              lss_cfg_q <= 1'b0;
              node_id_q <= stored_id_q;
              bt_q <= stored_bt_q;
            end
          end
          `CN_MSG_SW_SELECT: begin
            // mismatch falls through with nothing touched
            if (id_match && !lss_cfg_q) begin
              lss_cfg_q <= 1'b1;
              lss_ack_q <= 1'b1;
              pend_id_q <= node_id_q;
              pend_bt_q <= bt_q;
            end
          end
          `CN_MSG_CFG_ID: begin
            if (lss_cfg_q) begin
              lss_ack_q <= 1'b1;
              if (msg_arg[7] || msg_arg[6:0] < `CN_ID_MIN) begin
                lss_err_q <= 1'b1;
              end else begin
                pend_id_q <= msg_arg[6:0];
              end
            end
          end
          `CN_MSG_CFG_BT: begin
            if (lss_cfg_q) begin
              lss_ack_q <= 1'b1;
              if (msg_arg[7:4] != 4'h0 || msg_arg[3:0] > `CN_BT_MAX) begin
                lss_err_q <= 1'b1;
              end else begin
                pend_bt_q <= msg_arg[3:0];
              end
            end
          end
          `CN_MSG_STORE: begin
            if (lss_cfg_q) begin
              lss_ack_q <= 1'b1;
              stored_id_q <= pend_id_q;
              stored_bt_q <= pend_bt_q;
            end
          end
          default: lss_ack_q <= 1'b0;
        endcase
      end
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kbps_q <= `CN_KBPS_DEF;
    end else begin
      kbps_q <= bt_rate(bt_q);
    end
  end
  // network management state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmt_q <= `CN_ST_INIT;
    end else begin
      case (nmt_q)
        `CN_ST_INIT: nmt_q <= `CN_ST_PREOP;
        default: begin
          if (is_msg && msg_type == `CN_MSG_NMT) begin
            case (msg_arg)
              `CN_NMT_START: nmt_q <= `CN_ST_OP;
              `CN_NMT_STOP: nmt_q <= `CN_ST_STOP;
              `CN_NMT_PREOP: nmt_q <= `CN_ST_PREOP;
              `CN_NMT_RST_NODE: nmt_q <= `CN_ST_INIT;
              `CN_NMT_RST_COMM: nmt_q <= `CN_ST_INIT;
              default: nmt_q <= nmt_q;
            endcase
          end
        end
      endcase
    end
  end
  wire sdo_ok = (nmt_q == `CN_ST_PREOP) || (nmt_q == `CN_ST_OP);
  wire pdo_ok = (nmt_q == `CN_ST_OP);
  // tpdo triggers, millisecond tick compared at full integer width
  wire ms_tick = ({15'h0000, ms_cnt_q} == MS_CYCLES - 1);
  wire evt_run = pdo_ok && (tt_q == `CN_TT_EVENT) && (evt_q != 16'h0000);
  wire evt_fire = evt_run && ms_tick && (evt_cnt_q == evt_q - 16'h0001);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt_q <= 17'h00000;
      evt_cnt_q <= 16'h0000;
      tpdo_q <= 1'b0;
    end else begin
      if (!evt_run || ms_tick) begin
        ms_cnt_q <= 17'h00000;
      end else begin
        ms_cnt_q <= ms_cnt_q + 17'h00001;
      end
      if (!evt_run || evt_fire) begin
        evt_cnt_q <= 16'h0000;
      end else if (ms_tick) begin
        evt_cnt_q <= evt_cnt_q + 16'h0001;
      end
      tpdo_q <= (pdo_ok && tt_q == `CN_TT_SYNC && sync_in) || evt_fire;
    end
  end
  // object dictionary decode
  wire [15:0] od_idx = od_addr_q[15:0];
  wire [7:0] od_sub = od_addr_q[23:16];
  wire od_in_comm = (od_idx >= `CN_COMM_LO) && (od_idx <= `CN_COMM_HI);
  wire od_in_mfr = (od_idx >= `CN_MFR_LO) && (od_idx <= `CN_MFR_HI);
  wire od_in_dev = (od_idx >= `CN_DEV_LO) && (od_idx <= `CN_DEV_HI);
  wire [2:0] od_region = od_in_comm ? `CN_RG_COMM : od_in_mfr ? `CN_RG_MFR :
                         od_in_dev ? `CN_RG_DEV : `CN_RG_OTHER;
  wire [7:0] sub_m1 = od_sub - 8'h01;
  wire [3:0] mem_addr = {od_idx[1:0], sub_m1[1:0]};
  wire [31:0] mem_rdata;
  wire [10:0] tpdo_cob = `CN_COB_TPDO + {4'h0, node_id_q};
  wire [10:0] rpdo_cob = `CN_COB_RPDO + {4'h0, node_id_q};
  reg od_hit;
  reg od_wok;
  reg [31:0] od_val;
  always @* begin
    od_hit = 1'b0;
    od_wok = 1'b0;
    od_val = 32'h00000000;
    if (od_in_mfr) begin
      od_hit = (od_sub <= `CN_MFR_SUBS);
      od_wok = (od_sub != `CN_SUB_COUNT) && (od_sub <= `CN_MFR_SUBS);
      od_val = (od_sub == `CN_SUB_COUNT) ? {24'h000000, `CN_MFR_SUBS} : mem_rdata;
    end else if (od_idx == `CN_IDX_TPDO_COMM) begin
      od_hit = 1'b1;
      case (od_sub)
        `CN_SUB_COUNT: od_val = {24'h000000, `CN_TPDO_SUBS};
        `CN_SUB_COB: od_val = {21'h000000, tpdo_cob};
        `CN_SUB_TT: od_val = {24'h000000, tt_q};
        `CN_SUB_EVT: od_val = {16'h0000, evt_q};
        default: od_hit = 1'b0;
      endcase
      od_wok = (od_sub == `CN_SUB_TT) || (od_sub == `CN_SUB_EVT);
    end else if (od_idx == `CN_IDX_RPDO_COMM) begin
      od_hit = 1'b1;
      case (od_sub)
        `CN_SUB_COUNT: od_val = {24'h000000, `CN_RPDO_SUBS};
        `CN_SUB_COB: od_val = {21'h000000, rpdo_cob};
        `CN_SUB_TT: od_val = {24'h000000, `CN_TT_EVENT};
        default: od_hit = 1'b0;
      endcase
    end
  end
  // apb slave, zero wait except while an object fetch is in flight
  wire busy = |fetch_q;
  wire acc = psel && penable && !busy;
  wire wr = acc && pwrite;
  wire addr_ok = (paddr == `CN_OFF_STATUS) || (paddr == `CN_OFF_SERIAL) ||
                 (paddr == `CN_OFF_ODADDR) || (paddr == `CN_OFF_ODDATA) ||
                 (paddr == `CN_OFF_ODSTAT) || (paddr == `CN_OFF_NODE);
  wire od_wr = wr && (paddr == `CN_OFF_ODDATA);
  wire od_wr_ok = od_wr && od_wok && sdo_ok;
  wire mem_we = od_wr_ok && od_in_mfr;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_q <= `CN_SERIAL_RST;
      od_addr_q <= 32'h00000000;
      od_rdata_q <= 32'h00000000;
      od_err_q <= 1'b0;
      fetch_q <= 3'h0;
      tt_q <= `CN_TT_EVENT;
      evt_q <= `CN_EVT_DEF;
    end else begin
      fetch_q <= {fetch_q[1:0], wr && (paddr == `CN_OFF_ODADDR)};
      if (wr && paddr == `CN_OFF_SERIAL) begin
        serial_q <= pwdata;
      end
      if (wr && paddr == `CN_OFF_ODADDR) begin
        od_addr_q <= {8'h00, pwdata[23:0]};
      end
      if (fetch_q[1]) begin
        od_rdata_q <= (od_hit && sdo_ok) ? od_val : 32'h00000000;
        od_err_q <= !(od_hit && sdo_ok);
      end
      if (od_wr) begin
        od_err_q <= !od_wr_ok;
        if (od_wr_ok) begin
          od_rdata_q <= pwdata;
        end
      end
      if (od_wr_ok && od_idx == `CN_IDX_TPDO_COMM && od_sub == `CN_SUB_TT) begin
        tt_q <= pwdata[7:0];
      end
      if (od_wr_ok && od_idx == `CN_IDX_TPDO_COMM && od_sub == `CN_SUB_EVT) begin
        evt_q <= pwdata[15:0];
      end
    end
  end

  cnlss_od_mem u_mem (
    .pclk(pclk),
    .we(mem_we),
    .waddr(mem_addr),
    .wdata(pwdata),
    .raddr(mem_addr),
    .rdata(mem_rdata)
  );

  // read data is registered each cycle the slave is selected
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    case (paddr)
      `CN_OFF_STATUS: rd_mux = {16'h0000, tt_q, 3'h0, pdo_ok, sdo_ok, nmt_q, lss_cfg_q};
      `CN_OFF_SERIAL: rd_mux = serial_q;
      `CN_OFF_ODADDR: rd_mux = od_addr_q;
      `CN_OFF_ODDATA: rd_mux = od_rdata_q;
      `CN_OFF_ODSTAT: rd_mux = {28'h0000000, od_err_q, od_region};
      `CN_OFF_NODE: rd_mux = {8'h00, stored_bt_q, 1'b0, stored_id_q, bt_q, 1'b0, node_id_q};
      default: rd_mux = 32'h00000000;
    endcase
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (psel) begin
      prdata_q <= rd_mux;
    end
  end
  assign prdata = prdata_q;
  assign pready = !busy;
  assign pslverr = acc && !addr_ok;
  assign lss_config = lss_cfg_q;
  assign lss_ack = lss_ack_q;
  assign lss_err = lss_err_q;
  assign node_id = node_id_q;
  assign bit_timing = bt_q;
  assign bitrate_kbps = kbps_q;
  assign nmt_state = nmt_q;
  assign sdo_allowed = sdo_ok;
  assign pdo_allowed = pdo_ok;
  assign tpdo_tx = tpdo_q;
endmodule
`default_nettype wire

// ==== dv/cnlss_props.sv ====
// port assertions for the canopen node block
`timescale 1ns/1ps
`default_nettype none
`include "cnlss_regs.vh"
module cnlss_props #(
  parameter [31:0] VENDOR_ID = 32'h0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // messages
  input wire logic msg_valid,
  input wire logic [2:0] msg_type,
  input wire logic [7:0] msg_arg,
  input wire logic [31:0] msg_vendor,
  // node outputs
  input wire logic lss_config,
  input wire logic lss_ack,
  input wire logic lss_err,
  input wire logic [6:0] node_id,
  input wire logic [3:0] bit_timing,
  input wire logic [9:0] bitrate_kbps,
  input wire logic [1:0] nmt_state,
  input wire logic sdo_allowed,
  input wire logic pdo_allowed,
  input wire logic tpdo_tx
);
  localparam logic [9:0] RATE [0:8] = '{10'h3e8, 10'h320, 10'h1f4, 10'h0fa, 10'h07d,
    10'h064, 10'h032, 10'h014, 10'h00a};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire glob = msg_valid && msg_type == `CN_MSG_SW_GLOBAL;
  wire sw_wait = glob && msg_arg == `CN_SW_ARG_WAIT && lss_config;
  wire cfg_cmd = msg_valid && (msg_type == `CN_MSG_CFG_ID || msg_type == `CN_MSG_CFG_BT ||
    msg_type == `CN_MSG_STORE);
  sequence s_bad_id;
    lss_config && msg_valid && msg_type == `CN_MSG_CFG_ID && (msg_arg == 8'h00 || msg_arg > 8'h7f);
  endsequence
  sequence s_refused;
    lss_ack && lss_err;
  endsequence
  a_glob_cfg: assert property (glob && msg_arg == `CN_SW_ARG_CFG |=> lss_config)
    else $error("global switch not taken");
  a_rate_map: assert property (bitrate_kbps == RATE[$past(bit_timing)])
    else $error("rate does not follow timing index");
  a_hold_wait: assert property (!sw_wait |=> $stable(node_id) && $stable(bit_timing))
    else $error("settings changed outside switch");
  a_exit_wait: assert property (sw_wait |=> !lss_config)
    else $error("switch to waiting missed");
  a_sel_miss: assert property (msg_valid && msg_type == `CN_MSG_SW_SELECT &&
    msg_vendor != VENDOR_ID && !lss_config |=> !lss_config && !lss_ack)
    else $error("wrong identity accepted");
  a_bad_id: assert property (s_bad_id |=> s_refused)
    else $error("bad id not refused");
  a_no_ack_wait: assert property (!lss_config && cfg_cmd |=> !lss_ack)
    else $error("command acked while waiting");
  a_pdo_gate: assert property (tpdo_tx |-> $past(nmt_state) == `CN_ST_OP)
    else $error("pdo sent outside operational");
  a_perm_map: assert property (pdo_allowed == (nmt_state == `CN_ST_OP) &&
    sdo_allowed == (nmt_state == `CN_ST_PREOP || nmt_state == `CN_ST_OP))
    else $error("permission flags wrong");
endmodule
bind cnlss_node cnlss_props #(.VENDOR_ID(VENDOR_ID)) u_cnlss_props (.pclk(pclk),
  .presetn(presetn), .msg_valid(msg_valid), .msg_type(msg_type), .msg_arg(msg_arg),
  .msg_vendor(msg_vendor), .lss_config(lss_config), .lss_ack(lss_ack), .lss_err(lss_err),
  .node_id(node_id), .bit_timing(bit_timing), .bitrate_kbps(bitrate_kbps),
  .nmt_state(nmt_state), .sdo_allowed(sdo_allowed), .pdo_allowed(pdo_allowed),
  .tpdo_tx(tpdo_tx));
`default_nettype wire

// ==== dv/cnlss_master_model.sv ====
// bus master model issuing decoded can messages
`timescale 1ns/1ps
`default_nettype none
`include "cnlss_regs.vh"
module cnlss_master_model #(
  parameter [31:0] PRODUCT = `CN_PRODUCT_DEF,
  parameter [31:0] REVISION = `CN_REVISION_DEF
) (
  // clock
  input wire logic pclk,
  // decoded messages
  output logic msg_valid,
  output logic [2:0] msg_type,
  output logic [7:0] msg_arg,
  output logic [31:0] msg_vendor,
  output logic [31:0] msg_product,
  output logic [31:0] msg_revision,
  output logic [31:0] msg_serial
);
  initial begin
    msg_valid = 1'b0;
    msg_type = 3'h7;
    msg_arg = 8'h00;
    msg_vendor = 32'h0;
    msg_product = 32'h0;
    msg_revision = 32'h0;
    msg_serial = 32'h0;
  end
  // arg, vendor and serial lines are inverted once the message is gone
  task automatic put(input logic [2:0] t, input logic [7:0] a, input logic [31:0] v,
    input logic [31:0] s);
    @(posedge pclk);
    msg_valid <= 1'b1;
    msg_type <= t;
    msg_arg <= a;
    msg_vendor <= v;
    msg_product <= PRODUCT;
    msg_revision <= REVISION;
    msg_serial <= s;
    @(posedge pclk);
    msg_valid <= 1'b0;
    msg_arg <= ~a;
    msg_vendor <= ~v;
    msg_serial <= ~s;
  endtask
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// self-checking bench for the canopen node block
`timescale 1ns/1ps
`default_nettype none
`include "cnlss_regs.vh"
module testbench;
  // vendor code and serial are arbitrary
  localparam logic [31:0] VEND = 32'h00003c11;
  localparam logic [31:0] SER = 32'h0000abcd;
  localparam logic [9:0] RATE [0:8] = '{10'h3e8, 10'h320, 10'h1f4, 10'h0fa, 10'h07d,
    10'h064, 10'h032, 10'h014, 10'h00a};
  logic pclk, presetn, psel, penable, pwrite, erv;
  logic [11:0] paddr;
  logic [31:0] pwdata, rdv;
  wire logic [31:0] prdata, msg_vendor, msg_product, msg_revision, msg_serial;
  wire logic pready, pslverr, msg_valid, lss_config, lss_ack, lss_err, tpdo_tx;
  wire logic sdo_allowed, pdo_allowed;
  wire logic [2:0] msg_type;
  wire logic [7:0] msg_arg;
  wire logic [6:0] node_id;
  wire logic [3:0] bit_timing;
  wire logic [9:0] bitrate_kbps;
  wire logic [1:0] nmt_state;
  int error_cnt = 0;
  int checked = 0;
  // a single node on the bus while ids are assigned
  cnlss_node #(.VENDOR_ID(VEND), .MS_CYCLES(10)) u_cnlss_node (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .msg_valid(msg_valid), .msg_type(msg_type), .msg_arg(msg_arg), .msg_vendor(msg_vendor),
    .msg_product(msg_product), .msg_revision(msg_revision), .msg_serial(msg_serial),
    .lss_config(lss_config), .lss_ack(lss_ack), .lss_err(lss_err), .node_id(node_id),
    .bit_timing(bit_timing), .bitrate_kbps(bitrate_kbps), .nmt_state(nmt_state),
    .sdo_allowed(sdo_allowed), .pdo_allowed(pdo_allowed), .tpdo_tx(tpdo_tx));
  cnlss_master_model u_cnlss_master_model (.pclk(pclk), .msg_valid(msg_valid),
    .msg_type(msg_type), .msg_arg(msg_arg), .msg_vendor(msg_vendor),
    .msg_product(msg_product), .msg_revision(msg_revision), .msg_serial(msg_serial));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic od(input logic [7:0] sub, input logic [15:0] idx);
    apb(1'b1, `CN_OFF_ODADDR, {8'h00, sub, idx});
  endtask
  task automatic m(input logic [2:0] t, input logic [7:0] a);
    u_cnlss_master_model.put(t, a, VEND, SER);
    #1;
  endtask
  task automatic t_select;
    apb(1'b1, `CN_OFF_SERIAL, SER);
    u_cnlss_master_model.put(`CN_MSG_SW_SELECT, 8'h00, ~VEND, SER);
    #1;
    chk(32'({lss_config, lss_ack}), 32'h0);
    u_cnlss_master_model.put(`CN_MSG_SW_SELECT, 8'h00, VEND, ~SER);
    #1;
    chk(32'({lss_config, lss_ack}), 32'h0);
    m(`CN_MSG_SW_SELECT, 8'h00);
    chk(32'({lss_config, lss_ack}), 32'h3);
    m(`CN_MSG_SW_GLOBAL, `CN_SW_ARG_WAIT);
    chk(32'(lss_config), 32'h0);
  endtask
  task automatic t_lss;
    m(`CN_MSG_CFG_ID, 8'h71);
    chk(32'({lss_ack, node_id}), 32'h70);
    m(`CN_MSG_SW_GLOBAL, `CN_SW_ARG_CFG);
    chk(32'(lss_config), 32'h1);
    m(`CN_MSG_CFG_ID, 8'h00);
    chk(32'({lss_ack, lss_err}), 32'h3);
    m(`CN_MSG_CFG_ID, 8'h80);
    chk(32'({lss_ack, lss_err}), 32'h3);
    m(`CN_MSG_CFG_BT, 8'h09);
    chk(32'({lss_ack, lss_err}), 32'h3);
    for (int i = 0; i < 9; i++) begin
      m(`CN_MSG_SW_GLOBAL, `CN_SW_ARG_CFG);
      m(`CN_MSG_CFG_ID, 8'h77 + 8'(i));
      chk(32'({lss_ack, lss_err}), 32'h2);
      m(`CN_MSG_CFG_BT, 8'(i));
      m(`CN_MSG_STORE, 8'h00);
      m(`CN_MSG_SW_GLOBAL, `CN_SW_ARG_WAIT);
      chk(32'({bit_timing, node_id}), 32'({4'(i), 7'h77 + 7'(i)}));
      @(posedge pclk);
      #1;
      chk(32'(bitrate_kbps), 32'(RATE[i]));
    end
  endtask
  task automatic t_sync;
    od(8'h00, `CN_IDX_TPDO_COMM);
    apb(1'b0, `CN_OFF_ODDATA, 32'h0);
    chk(rdv, 32'h5);
    od(8'h01, `CN_IDX_TPDO_COMM);
    apb(1'b0, `CN_OFF_ODDATA, 32'h0);
    chk(rdv, 32'h1ff);
    od(8'h02, `CN_IDX_TPDO_COMM);
    apb(1'b1, `CN_OFF_ODDATA, 32'h1);
    m(`CN_MSG_NMT, `CN_NMT_START);
    chk(32'({pdo_allowed, nmt_state}), 32'h6);
    m(`CN_MSG_SYNC, 8'h00);
    chk(32'(tpdo_tx), 32'h1);
    @(posedge pclk);
    #1;
    chk(32'(tpdo_tx), 32'h0);
    m(`CN_MSG_NMT, `CN_NMT_STOP);
    m(`CN_MSG_SYNC, 8'h00);
    chk(32'({sdo_allowed, tpdo_tx}), 32'h0);
    m(`CN_MSG_NMT, `CN_NMT_PREOP);
  endtask
  task automatic t_event;
    int n;
    od(8'h02, `CN_IDX_TPDO_COMM);
    apb(1'b1, `CN_OFF_ODDATA, 32'hff);
    od(8'h05, `CN_IDX_TPDO_COMM);
    apb(1'b1, `CN_OFF_ODDATA, 32'h2);
    m(`CN_MSG_NMT, `CN_NMT_START);
    // first pulse one period after entering operational, then every period
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge pclk);
        #1;
        n++;
      end while (tpdo_tx !== 1'b1);
      chk(32'(n), 32'h14);
    end
    m(`CN_MSG_NMT, `CN_NMT_PREOP);
  endtask
  task automatic t_regions;
    logic [15:0] idx [0:3] = '{16'h1000, 16'h2000, 16'h6000, 16'ha000};
    logic [3:0] ex [0:3] = '{4'h9, 4'h2, 4'hb, 4'h8};
    for (int i = 0; i < 4; i++) begin
      od(8'h01, idx[i]);
      apb(1'b0, `CN_OFF_ODSTAT, 32'h0);
      chk(rdv & 32'hf, 32'(ex[i]));
    end
    od(8'h03, 16'h2003);
    apb(1'b1, `CN_OFF_ODDATA, 32'h1234abcd);
    od(8'h03, 16'h2003);
    apb(1'b0, `CN_OFF_ODDATA, 32'h0);
    chk(rdv, 32'h1234abcd);
    apb(1'b0, 12'h040, 32'h0);
    chk({rdv[30:0], erv}, 32'h1);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    #1;
    chk(32'({lss_config, node_id}), 32'h70);
    chk(32'(bitrate_kbps), 32'h00a);
    t_select;
    t_lss;
    t_sync;
    t_event;
    t_regions;
    tally_and_finish;
  end
  initial begin
    #200000;
    error_cnt++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
